// ===== src/timer_oc_defines.vh
// Register offsets, field positions, reset values and clock codes of the compare timer
`ifndef TIMER_OC_DEFINES_VH
`define TIMER_OC_DEFINES_VH

// ****************************************
// Register offsets
// ****************************************
`define TOC_ADDR_W          4
`define TOC_OFF_CTRL_FIRST  4'h0
`define TOC_OFF_CTRL_SECOND 4'h1
`define TOC_OFF_STATUS      4'h2
`define TOC_OFF_CMP1_HIGH   4'h3
`define TOC_OFF_CMP1_LOW    4'h4
`define TOC_OFF_CMP2_HIGH   4'h5
`define TOC_OFF_CMP2_LOW    4'h6
`define TOC_OFF_CNT_HIGH    4'h7
`define TOC_OFF_CNT_LOW     4'h8

// ****************************************
// Field positions
// ****************************************
`define TOC_CF1_IRQ_EN      7
`define TOC_CF1_LEVEL2      1
`define TOC_CF1_LEVEL1      0
`define TOC_CS_PIN_EN2      7
`define TOC_CS_PIN_EN1      6
`define TOC_CS_CLKSEL_HI    1
`define TOC_CS_CLKSEL_LO    0
`define TOC_SR_FLAG1        6
`define TOC_SR_FLAG2        3

// ****************************************
// Reset values, clock select codes and prescaler terminal counts
// ****************************************
`define TOC_CMP_RST         16'h8000
`define TOC_CNT_RST         16'h0000
`define TOC_CTRL_RST        8'h00
`define TOC_CLK_DIV4        2'h0
`define TOC_CLK_DIV2        2'h1
`define TOC_CLK_DIV8        2'h2
`define TOC_CLK_EXT         2'h3
`define TOC_PRESCALE_FACTOR_2         3'h1
`define TOC_PRESCALE_FACTOR_4         3'h3
`define TOC_PRESCALE_FACTOR_8         3'h7

`endif

// ===== src/compare_channel.v
// One output compare channel: value, inhibit, match flag, clear sequence and pin latch
`timescale 1ns/1ps
`include "timer_oc_defines.vh"

module compare_channel #(
	parameter WIDTH = 16
) (
	// Clock and reset
	input  wire             sys_clk,
	input  wire             sys_rst,
	// Timer side
	input  wire             tick,
	input  wire [WIDTH-1:0] count,
	// Software accesses
	input  wire             wr_high,
	input  wire             wr_low,
	input  wire             acc_low,
	input  wire             status_rd,
	input  wire [7:0]       wdata,
	// Configuration
	input  wire             compare_output_level,
	input  wire             compare_pin_enable,
	// State
	output reg  [WIDTH-1:0] compare_value_q,
	output reg              compare_match_flag_q,
	output reg              compare_output_pin_q
);

	reg inhibit_q;
	reg armed_q;
	wire match_evt;

	// ****************************************
	// Compare
	// ****************************************
	// Evaluated once per timer count, so resolution is one count
	assign match_evt = tick & ~inhibit_q & (count == compare_value_q);

	// Value only changes by software or reset
	always @(posedge sys_clk)
	begin
		if (sys_rst)
			compare_value_q <= `TOC_CMP_RST;
		else if (wr_high)
			compare_value_q <= {wdata, compare_value_q[7:0]};
		else if (wr_low)
			compare_value_q <= {compare_value_q[WIDTH-1:8], wdata};
	end

	// High write stalls compares until the low byte follows
	always @(posedge sys_clk)
	begin
		if (sys_rst)
			inhibit_q <= 1'b0;
		else if (wr_high)
			inhibit_q <= 1'b1;
		else if (wr_low)
			inhibit_q <= 1'b0;
	end

	// ****************************************
	// Flag and clearing sequence
	// ****************************************
	// Status read while set arms the clear; low byte access completes it
	always @(posedge sys_clk)
	begin
		if (sys_rst)
			armed_q <= 1'b0;
		else if (status_rd && compare_match_flag_q)
			armed_q <= 1'b1;
		else if (acc_low || !compare_match_flag_q)
			armed_q <= 1'b0;
	end

	// A match in the clearing cycle wins over the clear
	always @(posedge sys_clk)
	begin
		if (sys_rst)
			compare_match_flag_q <= 1'b0;
		else if (match_evt)
			compare_match_flag_q <= 1'b1;
		else if (wr_low || (acc_low && armed_q))
			compare_match_flag_q <= 1'b0;
	end

	// ****************************************
	// Pin latch
	// ****************************************
	always @(posedge sys_clk)
	begin
		if (sys_rst)
			compare_output_pin_q <= 1'b0;
		else if (match_evt && compare_pin_enable)
			compare_output_pin_q <= compare_output_level;
	end

endmodule

// ===== src/timer_output_compare.v
// Two-channel output compare with free-running counter, prescaler and register port
//
// Behaviour
// - Two independent compare channels, indexed one, two
// - 16-bit value compared every timer clock
// - Compare values changed only by software, reset
// - Compare values reset to 8000h
// - Match sets the channel's status flag
// - Pin enable dedicates pin to compare
// - Match drives pin to configured level
// - Pin latch held low during reset
// - Interrupt needs enable set and mask clear
// - Counter clocked at CPU clock over 2/4/8
// - Counter may count external clock periods
// - Resolution is one counter count
// - Status read then low access clears flag
// - High write inhibits; low write re-enables, clears
`timescale 1ns/1ps
`include "timer_oc_defines.vh"

module timer_output_compare #(
	parameter WIDTH = 16
) (
	// Clock and reset
	input  wire                   sys_clk,
	input  wire                   sys_rst,
	// Register port
	input  wire [`TOC_ADDR_W-1:0] reg_addr,
	input  wire [7:0]             reg_wdata,
	input  wire                   reg_wr,
	input  wire                   reg_rd,
	output reg  [7:0]             reg_rdata_q,
	// External timer clock and processor mask
	input  wire                   ext_timer_clk,
	input  wire                   cpu_irq_mask,
	// Compare pins and interrupt
	output reg  [1:0]             compare_output_pin_q,
	output reg  [1:0]             compare_pin_dedicated_q,
	output reg                    timer_irq_q
);

	// ****************************************
	// Control registers
	// ****************************************
	reg  [7:0]       timer_control_first_q;
	reg  [7:0]       timer_control_second_q;
	reg  [WIDTH-1:0] counter_q;
	reg  [2:0]       prescale_factor_cnt_q;
	reg              ext_prev_q;
	reg              tick;
	reg  [2:0]       prescale_factor_last;
	reg  [7:0]       rd_mux;
	wire [1:0]       timer_clock_select;
	wire             compare_irq_enable;
	wire [1:0]       compare_output_level;
	wire [1:0]       compare_pin_enable;
	wire [1:0]       flag;
	wire [1:0]       pin;
	wire [WIDTH-1:0] value1;
	wire [WIDTH-1:0] value2;
	wire             status_rd;

	assign timer_clock_select   = timer_control_second_q[`TOC_CS_CLKSEL_HI:`TOC_CS_CLKSEL_LO];
	assign compare_irq_enable   = timer_control_first_q[`TOC_CF1_IRQ_EN];
	assign compare_output_level = {timer_control_first_q[`TOC_CF1_LEVEL2],
		timer_control_first_q[`TOC_CF1_LEVEL1]};
	assign compare_pin_enable   = {timer_control_second_q[`TOC_CS_PIN_EN2],
		timer_control_second_q[`TOC_CS_PIN_EN1]};
	assign status_rd            = reg_rd && (reg_addr == `TOC_OFF_STATUS);

	// Software writes to the two control registers
	always @(posedge sys_clk)
	begin
		if (sys_rst)
		begin
			timer_control_first_q  <= `TOC_CTRL_RST;
			timer_control_second_q <= `TOC_CTRL_RST;
		end
		else if (reg_wr)
		begin
			if (reg_addr == `TOC_OFF_CTRL_FIRST)
				timer_control_first_q <= reg_wdata;
			if (reg_addr == `TOC_OFF_CTRL_SECOND)
				timer_control_second_q <= reg_wdata;
		end
	end

	// ****************************************
	// Timer clock generation
	// ****************************************
	// Terminal prescaler count for the chosen divide factor
	always @*
	begin
		case (timer_clock_select)
			`TOC_CLK_DIV2: prescale_factor_last = `TOC_PRESCALE_FACTOR_2;
			`TOC_CLK_DIV4: prescale_factor_last = `TOC_PRESCALE_FACTOR_4;
			`TOC_CLK_DIV8: prescale_factor_last = `TOC_PRESCALE_FACTOR_8;
			default:       prescale_factor_last = `TOC_PRESCALE_FACTOR_4;
		endcase
	end

	// External clock counts on its rising edge; it must be slower than half sys_clk
	always @*
	begin
		if (timer_clock_select == `TOC_CLK_EXT)
			tick = ext_timer_clk & ~ext_prev_q;
		else
			tick = (prescale_factor_cnt_q == prescale_factor_last);
	end

	always @(posedge sys_clk)
	begin
		if (sys_rst)
		begin
			prescale_factor_cnt_q <= 3'h0;
			ext_prev_q  <= 1'b0;
		end
		else
		begin
			ext_prev_q <= ext_timer_clk;
			if (timer_clock_select == `TOC_CLK_EXT || prescale_factor_cnt_q >= prescale_factor_last)
				prescale_factor_cnt_q <= 3'h0;
			else
				prescale_factor_cnt_q <= prescale_factor_cnt_q + 3'h1;
		end
	end

	// Free-running counter, one step per timer clock
	always @(posedge sys_clk)
	begin
		if (sys_rst)
			counter_q <= `TOC_CNT_RST;
		else if (tick)
			counter_q <= counter_q + {{(WIDTH-1){1'b0}}, 1'b1};
	end

	// ****************************************
	// Compare channels
	// ****************************************
	compare_channel #(.WIDTH(WIDTH)) u_channel1 (
		.sys_clk              (sys_clk),
		.sys_rst              (sys_rst),
		.tick                 (tick),
		.count                (counter_q),
		.wr_high              (reg_wr && reg_addr == `TOC_OFF_CMP1_HIGH),
		.wr_low               (reg_wr && reg_addr == `TOC_OFF_CMP1_LOW),
		.acc_low              ((reg_wr || reg_rd) && reg_addr == `TOC_OFF_CMP1_LOW),
		.status_rd            (status_rd),
		.wdata                (reg_wdata),
		.compare_output_level (compare_output_level[0]),
		.compare_pin_enable   (compare_pin_enable[0]),
		.compare_value_q      (value1),
		.compare_match_flag_q (flag[0]),
		.compare_output_pin_q (pin[0])
	);

	compare_channel #(.WIDTH(WIDTH)) u_channel2 (
		.sys_clk              (sys_clk),
		.sys_rst              (sys_rst),
		.tick                 (tick),
		.count                (counter_q),
		.wr_high              (reg_wr && reg_addr == `TOC_OFF_CMP2_HIGH),
		.wr_low               (reg_wr && reg_addr == `TOC_OFF_CMP2_LOW),
		.acc_low              ((reg_wr || reg_rd) && reg_addr == `TOC_OFF_CMP2_LOW),
		.status_rd            (status_rd),
		.wdata                (reg_wdata),
		.compare_output_level (compare_output_level[1]),
		.compare_pin_enable   (compare_pin_enable[1]),
		.compare_value_q      (value2),
		.compare_match_flag_q (flag[1]),
		.compare_output_pin_q (pin[1])
	);

	// ****************************************
	// Pins and interrupt
	// ****************************************
	// Registered copies so every output leaves from a flop; adds one cycle
	always @(posedge sys_clk)
	begin
		if (sys_rst)
		begin
			compare_output_pin_q    <= 2'h0;
			compare_pin_dedicated_q <= 2'h0;
			timer_irq_q             <= 1'b0;
		end
		else
		begin
			compare_output_pin_q    <= pin;
			compare_pin_dedicated_q <= compare_pin_enable;
			timer_irq_q <= (|flag) & compare_irq_enable & ~cpu_irq_mask;
		end
	end

	// ****************************************
	// Read path
	// ****************************************
	// Unmapped offsets read zero
	always @*
	begin
		rd_mux = 8'h00;
		case (reg_addr)
			`TOC_OFF_CTRL_FIRST:  rd_mux = timer_control_first_q;
			`TOC_OFF_CTRL_SECOND: rd_mux = timer_control_second_q;
			`TOC_OFF_STATUS:
			begin
				rd_mux[`TOC_SR_FLAG1] = flag[0];
				rd_mux[`TOC_SR_FLAG2] = flag[1];
			end
			`TOC_OFF_CMP1_HIGH:   rd_mux = value1[15:8];
			`TOC_OFF_CMP1_LOW:    rd_mux = value1[7:0];
			`TOC_OFF_CMP2_HIGH:   rd_mux = value2[15:8];
			`TOC_OFF_CMP2_LOW:    rd_mux = value2[7:0];
			`TOC_OFF_CNT_HIGH:    rd_mux = counter_q[15:8];
			`TOC_OFF_CNT_LOW:     rd_mux = counter_q[7:0];
			default:              rd_mux = 8'h00;
		endcase
	end

	// Data stand only in the cycle after the strobe
	always @(posedge sys_clk)
	begin
		if (sys_rst)
			reg_rdata_q <= 8'h00;
		else if (reg_rd)
			reg_rdata_q <= rd_mux;
		else
			reg_rdata_q <= 8'h00;
	end

endmodule

// ===== sim/compare_load.sv
// Load model standing on the two compare pins
`timescale 1ns/1ps

module compare_load (
	// Pin side of the block
	input  logic [1:0] pin_level,
	input  logic [1:0] pin_dedicated,
	// Level the load actually sees
	output logic [1:0] load_level
);
	// A pin not given to the compare logic is released; the pull-down wins
	assign load_level = pin_level & pin_dedicated;
endmodule

// ===== sim/timer_output_compare_assertions.sv
// Checker for the two-channel output compare block
`timescale 1ns/1ps
`include "timer_oc_defines.vh"

module timer_output_compare_checker (
	// Clock and reset
	input  logic       sys_clk,
	input  logic       sys_rst,
	// Register port
	input  logic [3:0] reg_addr,
	input  logic [7:0] reg_wdata,
	input  logic       reg_wr,
	input  logic       reg_rd,
	input  logic [7:0] reg_rdata_q,
	// Timer side
	input  logic       ext_timer_clk,
	input  logic       cpu_irq_mask,
	input  logic [1:0] compare_output_pin_q,
	input  logic [1:0] compare_pin_dedicated_q,
	input  logic       timer_irq_q
);
	logic [7:0]  ctrl_q;
	logic [15:0] cmp1_q;
	logic [15:0] cmp2_q;

	// Shadow of what software wrote; hardware may never alter the compares
	always @(posedge sys_clk)
		if (sys_rst)
		begin
			ctrl_q <= 8'h00;
			cmp1_q <= 16'h8000;
			cmp2_q <= 16'h8000;
		end
		else if (reg_wr)
		begin
			if (reg_addr == `TOC_OFF_CTRL_FIRST) ctrl_q <= reg_wdata;
			if (reg_addr == `TOC_OFF_CMP1_HIGH) cmp1_q[15:8] <= reg_wdata;
			if (reg_addr == `TOC_OFF_CMP1_LOW) cmp1_q[7:0] <= reg_wdata;
			if (reg_addr == `TOC_OFF_CMP2_HIGH) cmp2_q[15:8] <= reg_wdata;
			if (reg_addr == `TOC_OFF_CMP2_LOW) cmp2_q[7:0] <= reg_wdata;
		end

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (sys_rst);

	// Steps of the low-byte clear, its status check and the second control register write
	sequence s_low1_wr;
		reg_wr && reg_addr == `TOC_OFF_CMP1_LOW;
	endsequence
	sequence s_stat_rd;
		reg_rd && reg_addr == `TOC_OFF_STATUS;
	endsequence
	sequence s_ctl2_wr;
		reg_wr && reg_addr == `TOC_OFF_CTRL_SECOND;
	endsequence

	chk_rst_quiet: assert property (
		$past(sys_rst) |-> {compare_output_pin_q, timer_irq_q} == 3'h0)
		else $error("outputs not cleared by reset");
	chk_read_idle: assert property (!$past(reg_rd) |-> reg_rdata_q == 8'h00)
		else $error("read data outside read answer");
	chk_pin_dedicate: assert property (
		s_ctl2_wr ##2 1 |-> compare_pin_dedicated_q == $past(reg_wdata[7:6], 2))
		else $error("pin enable not copied");
	chk_irq_masked: assert property (
		(cpu_irq_mask || !ctrl_q[7])[*3] |-> !timer_irq_q)
		else $error("interrupt while masked");
	chk_irq_hold: assert property (
		(timer_irq_q && !cpu_irq_mask && ctrl_q[7] && !reg_wr && !reg_rd)[*4] |=> timer_irq_q)
		else $error("interrupt dropped on its own");
	chk_pin_level: assert property (
		$changed(compare_output_pin_q[0]) |-> compare_output_pin_q[0] == ctrl_q[0])
		else $error("pin took wrong level");
	chk_low_clears: assert property (
		s_low1_wr ##[1:2] s_stat_rd |=> !reg_rdata_q[`TOC_SR_FLAG1])
		else $error("low write left flag set");
	chk_cmp1_high: assert property (
		reg_rd && reg_addr == `TOC_OFF_CMP1_HIGH |=> reg_rdata_q == $past(cmp1_q[15:8]))
		else $error("compare high byte altered");
	chk_cmp2_low: assert property (
		reg_rd && reg_addr == `TOC_OFF_CMP2_LOW |=> reg_rdata_q == $past(cmp2_q[7:0]))
		else $error("compare low byte altered");
endmodule

bind timer_output_compare timer_output_compare_checker u_chk (
	.sys_clk(sys_clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
	.ext_timer_clk(ext_timer_clk), .cpu_irq_mask(cpu_irq_mask),
	.compare_output_pin_q(compare_output_pin_q),
	.compare_pin_dedicated_q(compare_pin_dedicated_q), .timer_irq_q(timer_irq_q));

// ===== sim/timer_output_compare_test.sv
// Self-checking bench for the two-channel output compare block
`timescale 1ns/1ps
`include "timer_oc_defines.vh"

module timer_output_compare_test;
	logic        sys_clk = 1'b0;
	logic        sys_rst = 1'b1;
	logic [3:0]  reg_addr = 4'h0;
	logic [7:0]  reg_wdata = 8'h00;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	logic        ext_timer_clk = 1'b0;
	logic        cpu_irq_mask = 1'b0;
	logic        ext_run = 1'b0;
	wire  [7:0]  reg_rdata_q;
	wire  [1:0]  pin_q;
	wire  [1:0]  dedicated_q;
	wire  [1:0]  load_level;
	wire         timer_irq_q;
	int          error_cnt = 0;
	int          tests_run = 0;
	int          cycles = 0;
	logic [7:0]  rd_q;
	logic [15:0] v;

	timer_output_compare DUT (
		.sys_clk(sys_clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
		.ext_timer_clk(ext_timer_clk), .cpu_irq_mask(cpu_irq_mask),
		.compare_output_pin_q(pin_q), .compare_pin_dedicated_q(dedicated_q),
		.timer_irq_q(timer_irq_q));
	compare_load u_load (.pin_level(pin_q), .pin_dedicated(dedicated_q), .load_level(load_level));

	// ****
	// Clock, external timer clock and hang limit
	// ****
	initial
		forever #12.5 sys_clk = ~sys_clk;
	always @(posedge sys_clk)
	begin
		cycles <= cycles + 1;
		if (ext_run && cycles % 4 == 0)
			ext_timer_clk <= ~ext_timer_clk;
		if (cycles == 20000)
		begin
			error_cnt++;
			end_of_test();
		end
	end

	// Compare and register bus tasks
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		tests_run++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a);
		@(posedge sys_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1;
		rd_q = reg_rdata_q;
	endtask
	task automatic end_of_test;
		$display("Checks %0d, errors %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// One match on a channel, then mask, hold and clear of its request
	task automatic match(input int ch, input logic lvl);
		logic [3:0] hi;
		logic [7:0] f;
		hi = ch == 1 ? `TOC_OFF_CMP1_HIGH : `TOC_OFF_CMP2_HIGH;
		f = ch == 1 ? 8'h40 : 8'h08;
		wr(`TOC_OFF_CTRL_FIRST, {1'b1, 5'h00, lvl, lvl});
		rd(`TOC_OFF_CNT_HIGH);
		v = {rd_q + 8'h02, 8'($urandom)};
		wr(hi, v[15:8]);
		rd(`TOC_OFF_STATUS);
		wr(hi + 4'h1, v[7:0]);
		for (int n = 0; n < 1000 && (rd_q & f) == 8'h00; n++)
			rd(`TOC_OFF_STATUS);
		chk("match flag", f, rd_q & 8'h48);
		repeat (3) @(posedge sys_clk);
		chk("pin level", {7'h00, lvl}, {7'h00, pin_q[ch - 1]});
		chk("load level", {7'h00, lvl}, {7'h00, load_level[ch - 1]});
		chk("irq raised", 8'h01, {7'h00, timer_irq_q});
		cpu_irq_mask <= 1'b1;
		repeat (4) @(posedge sys_clk);
		chk("irq masked", 8'h00, {7'h00, timer_irq_q});
		cpu_irq_mask <= 1'b0;
		repeat (8) @(posedge sys_clk);
		chk("irq held", 8'h01, {7'h00, timer_irq_q});
		rd(hi + 4'h1);
		rd(`TOC_OFF_STATUS);
		chk("flag cleared", 8'h00, rd_q & 8'h48);
		repeat (2) @(posedge sys_clk);
		chk("irq cleared", 8'h00, {7'h00, timer_irq_q});
	endtask

	// ****
	// Main sequence
	// ****
	initial
	begin
		logic [1:0] codes[4];
		int         per[4];
		codes = '{`TOC_CLK_DIV2, `TOC_CLK_DIV4, `TOC_CLK_DIV8, `TOC_CLK_EXT};
		per = '{2, 4, 8, 8};
		void'($urandom(32'hCDCC));
		repeat (12) @(posedge sys_clk);
		sys_rst <= 1'b0;
		for (int i = 0; i < 4; i++)
		begin
			rd(4'h3 + 4'(i));
			chk("compare reset", i[0] ? 8'h00 : 8'h80, rd_q);
		end
		rd(4'hF);
		chk("unmapped read", 8'h00, rd_q);
		wr(`TOC_OFF_STATUS, 8'hFF);
		rd(`TOC_OFF_STATUS);
		chk("status write", 8'h00, rd_q & 8'h48);
		// Random values kept above the counter's reach during the run
		for (int i = 0; i < 2; i++)
		begin
			v = {1'b1, 15'($urandom)};
			wr(4'h3 + 4'(2 * i), v[15:8]);
			wr(4'h4 + 4'(2 * i), v[7:0]);
			rd(4'h3 + 4'(2 * i));
			chk("compare high", v[15:8], rd_q);
			rd(4'h4 + 4'(2 * i));
			chk("compare low", v[7:0], rd_q);
		end
		// Any window of eight timer periods holds exactly eight counts
		for (int i = 0; i < 4; i++)
		begin
			wr(`TOC_OFF_CTRL_SECOND, {2'b11, 4'h0, codes[i]});
			ext_run <= codes[i] == `TOC_CLK_EXT;
			rd(`TOC_OFF_CNT_LOW);
			v[7:0] = rd_q;
			repeat (8 * per[i] - 2) @(posedge sys_clk);
			rd(`TOC_OFF_CNT_LOW);
			chk("count step", v[7:0] + 8'h08, rd_q);
		end
		ext_run <= 1'b0;
		wr(`TOC_OFF_CTRL_SECOND, 8'hC1);
		match(1, 1'b1);
		match(2, 1'b1);
		match(1, 1'b0);
		// High write alone keeps the channel quiet past its target
		rd(`TOC_OFF_CNT_HIGH);
		v = {rd_q + 8'h02, 8'h10};
		wr(`TOC_OFF_CMP1_HIGH, v[15:8]);
		wr(`TOC_OFF_CMP1_LOW, v[7:0]);
		wr(`TOC_OFF_CMP1_HIGH, v[15:8]);
		repeat (1600) @(posedge sys_clk);
		rd(`TOC_OFF_STATUS);
		chk("inhibited flag", 8'h00, rd_q & 8'h48);
		wr(`TOC_OFF_CMP1_LOW, v[7:0]);
		rd(`TOC_OFF_STATUS);
		chk("enabled flag", 8'h00, rd_q & 8'h48);
		// Second reset in mid-run, raised on a clock edge like every other input
		@(posedge sys_clk);
		sys_rst <= 1'b1;
		repeat (2) @(posedge sys_clk);
		sys_rst <= 1'b0;
		#1;
		chk("pins in reset", 8'h00, {6'h00, pin_q});
		rd(`TOC_OFF_CMP2_HIGH);
		chk("compare reset", 8'h80, rd_q);
		end_of_test();
	end
endmodule
